/* hdl/ddbl_pkg.sv */
`default_nettype none
package ddbl_pkg;
   // Latch selection codes: lsb is the first address line
   localparam logic [1:0] SEL_A_LOW = 2'h0;
   localparam logic [1:0] SEL_A_HIGH = 2'h1;
   localparam logic [1:0] SEL_B_LOW = 2'h2;
   localparam logic [1:0] SEL_B_HIGH = 2'h3;
   // Pin timing in ns
   localparam int CLK_PERIOD_NS = 25;
   localparam int WR_PULSE_NS = 100;
   localparam int DATA_SETUP_NS = 80;
   localparam int DATA_HOLD_NS = 20;
   localparam int LOAD_PULSE_NS = 100;
   // Least times round up to whole cycles
   localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [7:0] BUS_RESET = 8'h00;
   localparam logic [11:0] CODE_RESET = 12'h000;
   // One-hot sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SETUP = 7'h02,
      ST_STROBE = 7'h04,
      ST_HOLD = 7'h08,
      ST_NEXT = 7'h10,
      ST_LOAD = 7'h20,
      ST_DONE = 7'h40
   } ddbl_state_t;
endpackage
`default_nettype wire

/* hdl/ddbl_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ddbl_timer
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Control
   input wire logic start_i,
   input wire logic [ddbl_pkg::CNT_W-1:0] count_i,
   output logic done_o
);
   logic [ddbl_pkg::CNT_W-1:0] remain;

   // Counts down count_i cycles; done_o pulses in the cycle after the last one
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         remain <= '0;
         done_o <= 1'b0;
      end
      else if (start_i)
      begin
         remain <= count_i;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= (remain == 4'h1);
         if (remain != 4'h0)
            remain <= remain - 4'h1;
      end
   end
endmodule // ddbl_timer
`default_nettype wire

/* hdl/ddbl_host.sv */
// Overview of operation
// - Select held low around every write.
// - Write strobe pulsed low with address valid.
// - Lines 3..0 carry bits 3..0 or 11..8.
// - Lines 7..4 carry bits 7..4, low byte.
`timescale 1ns/1ps
`default_nettype none
module ddbl_host
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // User request
   input wire logic req_i,
   input wire logic [11:0] code_a_i,
   input wire logic [11:0] code_b_i,
   output logic busy_o,
   output logic done_o,
   // Device pins
   output logic dev_select_n_o,
   output logic write_strobe_n_o,
   output logic latch_sel_lsb_o,
   output logic latch_sel_msb_o,
   output logic [7:0] data_bus_o,
   output logic output_update_strobe_n_o
);
   ddbl_pkg::ddbl_state_t state;
   ddbl_pkg::ddbl_state_t next_state;
   logic [1:0] step;
   logic [11:0] code_a;
   logic [11:0] code_b;
   logic [11:0] code_cur;
   logic [7:0] next_bus;
   logic tmr_start;
   logic [ddbl_pkg::CNT_W-1:0] tmr_count;
   logic tmr_done;

   ddbl_timer u_timer
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .start_i(tmr_start),
      .count_i(tmr_count),
      .done_o(tmr_done)
   );

   // Steps: 0 A low, 1 A high, 2 B low, 3 B high
   assign code_cur = step[1] ? code_b : code_a;

   // Bus value for the write that the coming step performs
   always_comb
   begin
      // low byte, then high bits on lines 3..0
      // upper lines zero in the high nibble
      if (state == ddbl_pkg::ST_IDLE)
         next_bus = code_a_i[7:0];
      else if (step == 2'h3)
         next_bus = ddbl_pkg::BUS_RESET;
      else if (step[0])
         next_bus = code_b[7:0];
      else
         next_bus = {4'h0, code_cur[11:8]};
   end

   always_comb
   begin
      next_state = state;
      tmr_start = 1'b0;
      tmr_count = '0;
      case (state)
         ddbl_pkg::ST_IDLE:
         begin
            if (req_i)
            begin
               next_state = ddbl_pkg::ST_SETUP;
               tmr_start = 1'b1;
               tmr_count = ddbl_pkg::CNT_W'(ddbl_pkg::DATA_SETUP_CYC - ddbl_pkg::WR_PULSE_CYC + 1);
            end
         end
         ddbl_pkg::ST_SETUP:
         begin
            if (tmr_done)
            begin
               next_state = ddbl_pkg::ST_STROBE;
               tmr_start = 1'b1;
               tmr_count = ddbl_pkg::CNT_W'(ddbl_pkg::WR_PULSE_CYC);
            end
         end
         ddbl_pkg::ST_STROBE:
         begin
            if (tmr_done)
            begin
               next_state = ddbl_pkg::ST_HOLD;
               tmr_start = 1'b1;
               tmr_count = ddbl_pkg::CNT_W'(ddbl_pkg::DATA_HOLD_CYC);
            end
         end
         ddbl_pkg::ST_HOLD:
         begin
            if (tmr_done)
               next_state = ddbl_pkg::ST_NEXT;
         end
         ddbl_pkg::ST_NEXT:
         begin
            tmr_start = 1'b1;
            if (step == 2'h3)
            begin
               next_state = ddbl_pkg::ST_LOAD;
               tmr_count = ddbl_pkg::CNT_W'(ddbl_pkg::LOAD_PULSE_CYC);
            end
            else
            begin
               next_state = ddbl_pkg::ST_SETUP;
               tmr_count = ddbl_pkg::CNT_W'(ddbl_pkg::DATA_SETUP_CYC - ddbl_pkg::WR_PULSE_CYC + 1);
            end
         end
         ddbl_pkg::ST_LOAD:
         begin
            if (tmr_done)
               next_state = ddbl_pkg::ST_DONE;
         end
         ddbl_pkg::ST_DONE:
            next_state = ddbl_pkg::ST_IDLE;
         default:
            next_state = ddbl_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state <= ddbl_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   // Codes captured at request so the user may change inputs freely
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         code_a <= ddbl_pkg::CODE_RESET;
         code_b <= ddbl_pkg::CODE_RESET;
      end
      else if (state == ddbl_pkg::ST_IDLE && req_i)
      begin
         code_a <= code_a_i;
         code_b <= code_b_i;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         step <= 2'h0;
      else if (state == ddbl_pkg::ST_IDLE)
         step <= 2'h0;
      else if (state == ddbl_pkg::ST_NEXT)
         step <= step + 2'h1;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dev_select_n_o <= 1'b1;
      else
         dev_select_n_o <= !(next_state == ddbl_pkg::ST_SETUP ||
                             next_state == ddbl_pkg::ST_STROBE ||
                             next_state == ddbl_pkg::ST_HOLD);
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         write_strobe_n_o <= 1'b1;
      else
         write_strobe_n_o <= !(next_state == ddbl_pkg::ST_STROBE);
   end

   // address and data set up before strobe
   // held through hold time after strobe rises
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         latch_sel_lsb_o <= 1'b0;
         latch_sel_msb_o <= 1'b0;
         data_bus_o <= ddbl_pkg::BUS_RESET;
      end
      else if (state == ddbl_pkg::ST_IDLE || state == ddbl_pkg::ST_NEXT)
      begin
         latch_sel_lsb_o <= (state == ddbl_pkg::ST_NEXT) ? !step[0] : 1'b0;
         latch_sel_msb_o <= (state == ddbl_pkg::ST_NEXT) ? (step[1] ^ step[0]) : 1'b0;
         data_bus_o <= next_bus;
      end
   end

   // load strobe after all four latches written
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         output_update_strobe_n_o <= 1'b1;
      else
         output_update_strobe_n_o <= !(next_state == ddbl_pkg::ST_LOAD);
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         busy_o <= (next_state != ddbl_pkg::ST_IDLE);
         done_o <= (next_state == ddbl_pkg::ST_DONE);
      end
   end

endmodule // ddbl_host
`default_nettype wire

/* tb/ddbl_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ddbl_dev_model
(
   // Host pins
   input wire logic sel_n_i,
   input wire logic wr_n_i,
   input wire logic lsb_i,
   input wire logic msb_i,
   input wire logic [7:0] bus_i,
   input wire logic upd_n_i,
   // Converter codes
   output logic [11:0] out_a_o,
   output logic [11:0] out_b_o
);
   logic [7:0] lat [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [11:0] out_a = 12'h000;
   logic [11:0] out_b = 12'h000;
   assign out_a_o = out_a;
   assign out_b_o = out_b;
   // latch on strobe release
   // Release of select alone is not modelled; the host never ends a write that way
   always @(posedge wr_n_i)
   begin
      if (!sel_n_i)
         lat[{msb_i, lsb_i}] <= bus_i;
   end
   always @(negedge upd_n_i)
   begin
      out_a <= {lat[1][3:0], lat[0]};
      out_b <= {lat[3][3:0], lat[2]};
   end
endmodule // ddbl_dev_model
`default_nettype wire

/* tb/ddbl_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ddbl_host_asserts
(
   // Clock, reset and request
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic req_i,
   input wire logic busy_o,
   input wire logic done_o,
   // Device pins
   input wire logic dev_select_n_o,
   input wire logic write_strobe_n_o,
   input wire logic latch_sel_lsb_o,
   input wire logic latch_sel_msb_o,
   input wire logic [7:0] data_bus_o,
   input wire logic output_update_strobe_n_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   property p_wr_sel; !write_strobe_n_o |-> !dev_select_n_o; endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
   // Timer done_o is registered, so each strobe runs one cycle past its least count
   property p_wr_len; $fell(write_strobe_n_o) |-> !write_strobe_n_o [*5] ##1 write_strobe_n_o;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("strobe width");
   property p_stable;
      !write_strobe_n_o |-> $stable({data_bus_o, latch_sel_msb_o, latch_sel_lsb_o});
   endproperty
   a_stable: assert property (p_stable) else $error("bus moved in strobe");
   property p_hold; $rose(write_strobe_n_o) |-> !dev_select_n_o && $stable(data_bus_o);
   endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_nib; !write_strobe_n_o && latch_sel_lsb_o |-> data_bus_o[7:4] == 4'h0;
   endproperty
   a_nib: assert property (p_nib) else $error("upper lines in nibble");
   property p_upd; $fell(output_update_strobe_n_o) |-> !output_update_strobe_n_o [*5]
      ##1 output_update_strobe_n_o;
   endproperty
   a_upd: assert property (p_upd) else $error("load width");
   property p_start; req_i && !busy_o |=> busy_o && !dev_select_n_o; endproperty
   a_start: assert property (p_start) else $error("request not taken");
   property p_done; done_o |=> !done_o && !busy_o; endproperty
   a_done: assert property (p_done) else $error("done pulse");
   c_done: cover property (done_o);
   c_upd: cover property ($fell(output_update_strobe_n_o));
   c_b_high: cover property (!write_strobe_n_o && latch_sel_msb_o && latch_sel_lsb_o);
endmodule // ddbl_host_asserts
bind ddbl_host ddbl_host_asserts i_chk(.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i),
   .busy_o(busy_o), .done_o(done_o), .dev_select_n_o(dev_select_n_o),
   .write_strobe_n_o(write_strobe_n_o), .latch_sel_lsb_o(latch_sel_lsb_o),
   .latch_sel_msb_o(latch_sel_msb_o), .data_bus_o(data_bus_o),
   .output_update_strobe_n_o(output_update_strobe_n_o));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
$display("MISMATCH %s expected %h seen %h", n, e, s); end end
module tb;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic req_i = 1'b0;
   logic [11:0] code_a_i = 12'h000;
   logic [11:0] code_b_i = 12'h000;
   logic busy_o, done_o, sel_n, wr_n, lsb, msb, upd_n;
   logic [7:0] bus;
   logic [11:0] out_a, out_b;
   int errors = 0;
   int total_checks = 0;
   always #12.5 mclk_i = ~mclk_i;
   ddbl_host i_dut(.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i), .code_a_i(code_a_i),
      .code_b_i(code_b_i), .busy_o(busy_o), .done_o(done_o), .dev_select_n_o(sel_n),
      .write_strobe_n_o(wr_n), .latch_sel_lsb_o(lsb), .latch_sel_msb_o(msb),
      .data_bus_o(bus), .output_update_strobe_n_o(upd_n));
   ddbl_dev_model i_dev(.sel_n_i(sel_n), .wr_n_i(wr_n), .lsb_i(lsb), .msb_i(msb),
      .bus_i(bus), .upd_n_i(upd_n), .out_a_o(out_a), .out_b_o(out_b));
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Poke raises a request mid-sequence, which must be ignored
   task run(input logic [11:0] a, input logic [11:0] b, input bit poke);
      @(posedge mclk_i);
      req_i <= 1'b1;
      code_a_i <= a;
      code_b_i <= b;
      @(posedge mclk_i);
      req_i <= 1'b0;
      code_a_i <= ~a;
      code_b_i <= ~b;
      @(negedge mclk_i);
      `CHK("busy", 1'b1, busy_o)
      if (poke)
      begin
         repeat (6) @(posedge mclk_i);
         req_i <= 1'b1;
         @(posedge mclk_i);
         req_i <= 1'b0;
      end
      for (int i = 0; i < 400; i++)
      begin
         @(negedge mclk_i);
         if (done_o === 1'b1)
            break;
      end
      `CHK("done seen", 1'b1, done_o)
      `CHK("out_a", a, out_a)
      `CHK("out_b", b, out_b)
      @(negedge mclk_i);
      `CHK("done", 1'b0, done_o)
      `CHK("idle", 1'b0, busy_o)
   endtask
   // Reset in mid-strobe: pins idle at once, next update still lands
   task t_mid_reset;
      @(posedge mclk_i);
      req_i <= 1'b1;
      code_a_i <= 12'h3C5;
      @(posedge mclk_i);
      req_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      nrst_i <= 1'b0;
      @(negedge mclk_i);
      `CHK("select", 1'b1, sel_n)
      `CHK("strobe", 1'b1, wr_n)
      `CHK("load", 1'b1, upd_n)
      `CHK("busy", 1'b0, busy_o)
      // Two edges in reset so the edge checks see a clean history
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      run(12'h1A2, 12'hE4D, 1'b0);
   endtask
   task t_reset;
      @(negedge mclk_i);
      `CHK("select", 1'b1, sel_n)
      `CHK("strobe", 1'b1, wr_n)
      `CHK("load", 1'b1, upd_n)
      `CHK("bus", 8'h00, bus)
   endtask
   task t_update;
      run(12'hABC, 12'h5F3, 1'b0);
   endtask
   task t_back_to_back;
      run(12'hFFF, 12'h000, 1'b0);
      run(12'h81E, 12'h7E1, 1'b0);
   endtask
   task t_busy_refused;
      run(12'h000, 12'hFFF, 1'b1);
   endtask
   initial
   begin
      t_reset();
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_update();
      t_back_to_back();
      t_busy_refused();
      t_mid_reset();
      print_verdict();
   end
   initial
   begin
      repeat (2000) @(posedge mclk_i);
      errors++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
